// ===== hdl/wdg_pkg.sv
/*
 watchdog package: register offsets, bit positions, reset values, prescale counts and bus carrier struct.
 assumes a 32-bit APB register bus with byte addresses.
*/
package wdg_pkg;
   // ==========================================================
   // register map (byte addresses: register index times four)
   localparam logic [15:0] IDX_CTRL_STATUS = 16'hFFC0;
   localparam logic [15:0] IDX_COUNTER = 16'hFFC1;
   localparam logic [15:0] IDX_PORT_MODE_TWO = 16'hFFE0;
   localparam logic [17:0] ADDR_CTRL_STATUS = {IDX_CTRL_STATUS, 2'b00};
   localparam logic [17:0] ADDR_COUNTER = {IDX_COUNTER, 2'b00};
   localparam logic [17:0] ADDR_PORT_MODE_TWO = {IDX_PORT_MODE_TWO, 2'b00};
   localparam logic [17:0] ADDR_IRQ_STATUS = 18'h00100;
   localparam logic [17:0] ADDR_IRQ_MASK = 18'h00104;
   // ==========================================================
   // control/status bit positions
   localparam int BIT_CNT_WE_GUARD = 7;
   localparam int BIT_CNT_WE = 6;
   localparam int BIT_REG_WE_GUARD = 5;
   localparam int BIT_LOW_WE = 4;
   localparam int BIT_WATCHDOG_ON_GUARD = 3;
   localparam int BIT_WATCHDOG_ON = 2;
   localparam int BIT_FLAG_GUARD = 1;
   localparam int BIT_FLAG = 0;
   localparam int BIT_SRC_SEL = 2;
   // ==========================================================
   // reset values and counter limits
   localparam logic [7:0] CS_RESET = 8'h00;
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] PM2_RESET = 8'h00;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   localparam int IRQ_OVF = 0;
   localparam int IRQ_CNTWR = 1;
   // ==========================================================
   // prescale counts
   localparam int SYS_DIV = 8192;
   localparam int SUB_DIV = 32;
   localparam logic [12:0] SYS_LAST = 13'(SYS_DIV - 1);
   localparam logic [12:0] SUB_LAST = 13'(SUB_DIV - 1);
   localparam logic [12:0] PRE_ZERO = 13'h0000;
   localparam logic [31:0] RDATA_ZERO = 32'h00000000;

   // apb request carrier
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } wdg_apb_req_s;
endpackage

// ===== hdl/wdg_top.sv
/*
 watchdog timer with write-guarded control/status register, 8-bit counter and clock source select.
 assumes a single pclk domain; the subclock arrives as a synchronous one-cycle tick input.
*/
// The APB slave port was left to the implementer.
// Notes on behaviour
// - bit 6 takes a write only when the same write carries zero in bit 7.
// - counter accepts a full 8-bit write only while bit 6 is one.
// - bit 4 takes a write only when bit 5 of that write is zero.
// - bits 2 and 0 accept writes only while bit 4 is one.
// - bit 2 takes a write only when bit 3 of that write is zero.
// - watchdog runs while bit 2 is one, stays idle while zero.
// - bit 0 takes a write only when bit 1 of that write is zero.
// - bit 0 is set on overflow with internal reset; otherwise it keeps the value last written.
// - counter is an 8-bit up-counter on a prescaled clock, system clock over 8192 or subclock over 32.
// - source select zero picks system clock over 8192, one picks subclock over 32.
`timescale 1ns/100ps
module wdg_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // subclock tick, one cycle per subclock period
   input wire logic sub_tick,
   // outputs
   output logic wdt_reset,
   output logic irq
);
   // ==========================================================
   // bus decode
   wdg_pkg::wdg_apb_req_s req;
   logic wr_acc;
   logic hit_cs, hit_cnt, hit_pm2, hit_ist, hit_imk, hit_any;
   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
   assign hit_cs = req.addr[17:0] == wdg_pkg::ADDR_CTRL_STATUS && req.addr[31:18] == '0;
   assign hit_cnt = req.addr[17:0] == wdg_pkg::ADDR_COUNTER && req.addr[31:18] == '0;
   assign hit_pm2 = req.addr[17:0] == wdg_pkg::ADDR_PORT_MODE_TWO && req.addr[31:18] == '0;
   assign hit_ist = req.addr[17:0] == wdg_pkg::ADDR_IRQ_STATUS && req.addr[31:18] == '0;
   assign hit_imk = req.addr[17:0] == wdg_pkg::ADDR_IRQ_MASK && req.addr[31:18] == '0;
   assign hit_any = hit_cs | hit_cnt | hit_pm2 | hit_ist | hit_imk;
   assign wr_acc = req.sel & req.enable & req.write;
   // zero-wait slave, error on unmapped address
   assign pready = 1'b1;
   assign pslverr = req.sel & req.enable & ~hit_any;

   // ==========================================================
   // control/status register
   logic [7:0] cs_reg, cs_next;
   logic [7:0] wd;
   logic [7:0] cnt_reg, cnt_next;
   logic [7:0] pm2_reg;
   logic ovf;
   assign wd = req.wdata[7:0];
   // guarded per-bit update; odd guard bits always read zero
   always_comb begin
      cs_next = cs_reg;
      if (wr_acc && hit_cs) begin
         if (!wd[wdg_pkg::BIT_CNT_WE_GUARD]) begin
            cs_next[wdg_pkg::BIT_CNT_WE] = wd[wdg_pkg::BIT_CNT_WE];
         end
         if (!wd[wdg_pkg::BIT_REG_WE_GUARD]) begin
            cs_next[wdg_pkg::BIT_LOW_WE] = wd[wdg_pkg::BIT_LOW_WE];
         end
         if (cs_reg[wdg_pkg::BIT_LOW_WE] && !wd[wdg_pkg::BIT_WATCHDOG_ON_GUARD]) begin
            cs_next[wdg_pkg::BIT_WATCHDOG_ON] = wd[wdg_pkg::BIT_WATCHDOG_ON];
         end
         if (cs_reg[wdg_pkg::BIT_LOW_WE] && !wd[wdg_pkg::BIT_FLAG_GUARD]) begin
            cs_next[wdg_pkg::BIT_FLAG] = wd[wdg_pkg::BIT_FLAG];
         end
      end
      // overflow sets the flag, winning over a clearing write
      if (ovf) begin
         cs_next[wdg_pkg::BIT_FLAG] = 1'b1;
      end
      cs_next[wdg_pkg::BIT_CNT_WE_GUARD] = 1'b0;
      cs_next[wdg_pkg::BIT_REG_WE_GUARD] = 1'b0;
      cs_next[wdg_pkg::BIT_WATCHDOG_ON_GUARD] = 1'b0;
      cs_next[wdg_pkg::BIT_FLAG_GUARD] = 1'b0;
   end

   // control/status storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_reg <= wdg_pkg::CS_RESET;
      end else begin
         cs_reg <= cs_next;
      end
   end

   // port mode two storage, only source select is live
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm2_reg <= wdg_pkg::PM2_RESET;
      end else if (wr_acc && hit_pm2) begin
         pm2_reg <= wd;
      end
   end

   // ==========================================================
   // prescaler
   logic [12:0] pre_reg;
   logic [12:0] pre_last;
   logic src_sub, pre_step, tick_en, wd_on, src_chg;
   assign wd_on = cs_reg[wdg_pkg::BIT_WATCHDOG_ON];
   assign src_sub = pm2_reg[wdg_pkg::BIT_SRC_SEL];
   assign pre_last = src_sub ? wdg_pkg::SUB_LAST : wdg_pkg::SYS_LAST;
   assign pre_step = src_sub ? sub_tick : 1'b1;
   assign tick_en = wd_on & pre_step & (pre_reg >= pre_last);
   // a source switch restarts the prescaler, so a long system count cannot give an early subclock step
   assign src_chg = wr_acc & hit_pm2 & (wd[wdg_pkg::BIT_SRC_SEL] != src_sub);

   // divide system clock by 8192 or subclock ticks by 32
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_reg <= wdg_pkg::PRE_ZERO;
      end else if (!wd_on || src_chg) begin
         pre_reg <= wdg_pkg::PRE_ZERO;
      end else if (pre_step) begin
         pre_reg <= (pre_reg >= pre_last) ? wdg_pkg::PRE_ZERO : 13'(pre_reg + 13'h0001);
      end
   end

   // ==========================================================
   // counter
   logic cnt_wr;
   assign cnt_wr = wr_acc & hit_cnt & cs_reg[wdg_pkg::BIT_CNT_WE];
   assign ovf = tick_en & (cnt_reg == wdg_pkg::CNT_MAX) & ~cnt_wr;

   // software write beats a count step
   always_comb begin
      cnt_next = cnt_reg;
      if (cnt_wr) begin
         cnt_next = wd;
      end else if (tick_en) begin
         cnt_next = 8'(cnt_reg + 8'h01);
      end
   end

   // counter storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= wdg_pkg::CNT_RESET;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // internal reset pulse, one cycle after overflow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_reset <= 1'b0;
      end else begin
         wdt_reset <= ovf;
      end
   end

   // ==========================================================
   // interrupts: bit0 overflow, bit1 refused counter write
   logic [1:0] ist_reg, imk_reg, ist_set;
   assign ist_set[wdg_pkg::IRQ_OVF] = ovf;
   assign ist_set[wdg_pkg::IRQ_CNTWR] = wr_acc & hit_cnt & ~cs_reg[wdg_pkg::BIT_CNT_WE];

   // sticky status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_reg <= wdg_pkg::IRQ_RESET;
      end else if (wr_acc && hit_ist) begin
         ist_reg <= (ist_reg & ~wd[1:0]) | ist_set;
      end else begin
         ist_reg <= ist_reg | ist_set;
      end
   end

   // interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imk_reg <= wdg_pkg::IRQ_RESET;
      end else if (wr_acc && hit_imk) begin
         imk_reg <= wd[1:0];
      end
   end

   assign irq = |(ist_reg & imk_reg);

   // ==========================================================
   // read mux, picked from the address held since the setup cycle
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = wdg_pkg::RDATA_ZERO;
      if (hit_cs) rd_mux[7:0] = cs_reg;
      if (hit_cnt) rd_mux[7:0] = cnt_reg;
      if (hit_pm2) rd_mux[7:0] = pm2_reg;
      if (hit_ist) rd_mux[1:0] = ist_reg;
      if (hit_imk) rd_mux[1:0] = imk_reg;
   end

   // read data flop, loaded at the end of setup so it stands through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= wdg_pkg::RDATA_ZERO;
      end else begin
         prdata <= rd_mux;
      end
   end

   // ==========================================================
   // checks
   logic cs_wr;
   logic low_open;
   // a control/status write, and one that may reach bits 2 and 0
   assign cs_wr = wr_acc & hit_cs;
   assign low_open = cs_wr & cs_reg[wdg_pkg::BIT_LOW_WE];

   // counter at its top while the prescaler wraps and software does not load it
   sequence s_ovf_step;
      wd_on && tick_en && cnt_reg == wdg_pkg::CNT_MAX && !cnt_wr;
   endsequence

   // the cycle after an overflow: reset pulse, flag set, counter back at zero
   sequence s_ovf_result;
      wdt_reset && cs_reg[wdg_pkg::BIT_FLAG] && cnt_reg == wdg_pkg::CNT_RESET;
   endsequence

   // counter write enable holds under its guard
   chk_bit6_guard: assert property (@(posedge pclk) disable iff (!presetn)
      cs_wr && wd[wdg_pkg::BIT_CNT_WE_GUARD] |=> $stable(cs_reg[wdg_pkg::BIT_CNT_WE]))
      else $error("counter write enable changed under guard");
   // counter write enable follows an unguarded write
   chk_bit6_write: assert property (@(posedge pclk) disable iff (!presetn)
      cs_wr && !wd[wdg_pkg::BIT_CNT_WE_GUARD] |=> cs_reg[wdg_pkg::BIT_CNT_WE] == $past(wd[wdg_pkg::BIT_CNT_WE]))
      else $error("counter write enable not updated");
   // a locked counter ignores software
   chk_counter_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && hit_cnt && !cs_reg[wdg_pkg::BIT_CNT_WE] && !tick_en |=> $stable(cnt_reg))
      else $error("counter written while locked");
   // an unlocked counter takes the full byte
   chk_counter_load: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_wr |=> cnt_reg == $past(wd))
      else $error("counter load lost");
   // register write enable follows an unguarded write
   chk_bit4_guard: assert property (@(posedge pclk) disable iff (!presetn)
      cs_wr && !wd[wdg_pkg::BIT_REG_WE_GUARD] |=> cs_reg[wdg_pkg::BIT_LOW_WE] == $past(wd[wdg_pkg::BIT_LOW_WE]))
      else $error("register write enable not updated");
   // register write enable holds under its guard
   chk_bit4_hold: assert property (@(posedge pclk) disable iff (!presetn)
      cs_wr && wd[wdg_pkg::BIT_REG_WE_GUARD] |=> $stable(cs_reg[wdg_pkg::BIT_LOW_WE]))
      else $error("register write enable changed under guard");
   // watchdog on bit locked while register write enable is low
   chk_low_lock: assert property (@(posedge pclk) disable iff (!presetn)
      cs_wr && !cs_reg[wdg_pkg::BIT_LOW_WE] |=> $stable(cs_reg[wdg_pkg::BIT_WATCHDOG_ON]))
      else $error("watchdog on written while locked");
   // reset flag locked while register write enable is low
   chk_flag_lock: assert property (@(posedge pclk) disable iff (!presetn)
      cs_wr && !cs_reg[wdg_pkg::BIT_LOW_WE] && !ovf |=> $stable(cs_reg[wdg_pkg::BIT_FLAG]))
      else $error("flag written while locked");
   // watchdog on follows an open unguarded write
   chk_watchdog_on_guard: assert property (@(posedge pclk) disable iff (!presetn)
      low_open && !wd[wdg_pkg::BIT_WATCHDOG_ON_GUARD] |=> cs_reg[wdg_pkg::BIT_WATCHDOG_ON] == $past(wd[wdg_pkg::BIT_WATCHDOG_ON]))
      else $error("watchdog on not updated");
   // watchdog on holds under its guard
   chk_watchdog_on_hold: assert property (@(posedge pclk) disable iff (!presetn)
      low_open && wd[wdg_pkg::BIT_WATCHDOG_ON_GUARD] |=> $stable(cs_reg[wdg_pkg::BIT_WATCHDOG_ON]))
      else $error("watchdog on changed under guard");
   // counter frozen while the watchdog is off
   chk_idle_counter: assert property (@(posedge pclk) disable iff (!presetn)
      !wd_on && !cnt_wr |=> $stable(cnt_reg))
      else $error("counter moved while off");
   // prescaler held clear while the watchdog is off
   chk_idle_prescale: assert property (@(posedge pclk) disable iff (!presetn)
      !wd_on |=> pre_reg == wdg_pkg::PRE_ZERO)
      else $error("prescaler ran while off");
   // reset flag holds under its guard
   chk_flag_guard: assert property (@(posedge pclk) disable iff (!presetn)
      cs_wr && wd[wdg_pkg::BIT_FLAG_GUARD] && !ovf |=> $stable(cs_reg[wdg_pkg::BIT_FLAG]))
      else $error("flag changed under guard");
   // reset flag follows an open unguarded write
   chk_flag_write: assert property (@(posedge pclk) disable iff (!presetn)
      low_open && !wd[wdg_pkg::BIT_FLAG_GUARD] && !ovf
      |=> cs_reg[wdg_pkg::BIT_FLAG] == $past(wd[wdg_pkg::BIT_FLAG]))
      else $error("flag not updated");
   // overflow gives reset pulse, flag and wrapped counter
   chk_ovf_reset: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovf_step |=> s_ovf_result)
      else $error("overflow not seen");
   // flag moves only on overflow or an open write
   chk_flag_source: assert property (@(posedge pclk) disable iff (!presetn)
      !ovf && !(low_open && !wd[wdg_pkg::BIT_FLAG_GUARD]) |=> $stable(cs_reg[wdg_pkg::BIT_FLAG]))
      else $error("flag moved without cause");
   // counter steps by one per prescaler wrap
   chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
      tick_en && !cnt_wr |=> cnt_reg == 8'($past(cnt_reg) + 8'h01))
      else $error("bad count step");
   // system source steps only at the last prescaler count
   chk_sys_rate: assert property (@(posedge pclk) disable iff (!presetn)
      tick_en && !src_sub |-> pre_reg == wdg_pkg::SYS_LAST)
      else $error("system clock rate wrong");
   // subclock source steps only at the last prescaler count
   chk_sub_rate: assert property (@(posedge pclk) disable iff (!presetn)
      tick_en && src_sub |-> pre_reg == wdg_pkg::SUB_LAST)
      else $error("subclock rate wrong");
   // no internal reset while the watchdog is off
   chk_reset_enabled: assert property (@(posedge pclk) disable iff (!presetn)
      !wd_on |=> !wdt_reset)
      else $error("reset while watchdog off");
   // a guarded bit and an open bit in one write
   chk_mixed_write: assert property (@(posedge pclk) disable iff (!presetn)
      cs_wr && wd[wdg_pkg::BIT_CNT_WE_GUARD] && !wd[wdg_pkg::BIT_REG_WE_GUARD]
      |=> $stable(cs_reg[wdg_pkg::BIT_CNT_WE]) && cs_reg[wdg_pkg::BIT_LOW_WE] == $past(wd[wdg_pkg::BIT_LOW_WE]))
      else $error("mixed guarded write wrong");
endmodule

// ===== tb/wdg_top_tb.sv
/*
 testbench for the guarded watchdog: apb tasks, register tests, overflow on both clock sources.
 assumes wdg_top and wdg_pkg compiled first; assertions live in the design.
*/
`timescale 1ns/100ps
module wdg_top_tb;
   // ==========================================================
   // signals and constants
   localparam logic [31:0] CS = 32'(wdg_pkg::ADDR_CTRL_STATUS);
   localparam logic [31:0] CN = 32'(wdg_pkg::ADDR_COUNTER);
   localparam logic [31:0] PM = 32'(wdg_pkg::ADDR_PORT_MODE_TWO);
   localparam logic [31:0] IS = 32'(wdg_pkg::ADDR_IRQ_STATUS);
   localparam logic [31:0] IM = 32'(wdg_pkg::ADDR_IRQ_MASK);
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sub_tick = 0, tick_on = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata;
   logic pready, pslverr, wdt_reset, irq, last_err;
   logic [1:0] tdiv = 0;
   int err_count = 0, checks = 0, rst_cnt = 0, cyc;

   wdg_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sub_tick(sub_tick), .wdt_reset(wdt_reset), .irq(irq));

   // clock, subclock tick every fourth cycle, reset pulse count
   initial forever #2 pclk = ~pclk;
   always @(posedge pclk) begin
      tdiv <= tdiv + 2'h1;
      sub_tick <= tick_on && (tdiv == 2'h3);
   end
   always @(negedge pclk) if (wdt_reset === 1'b1) rst_cnt++;

   // ==========================================================
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      apb(1'b0, a, 32'h00000000, r);
      check(r, exp);
   endtask
   task automatic wait_rst(input int lim);
      cyc = 0;
      while (wdt_reset !== 1'b1 && cyc < lim) begin
         @(negedge pclk);
         cyc++;
      end
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // watchdog on a hung run
   initial begin
      #160000;
      err_count++;
      report_and_stop();
   end

   // ==========================================================
   // tests
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // reset values
      rd(CS, 32'h00);
      rd(CN, 32'h00);
      rd(PM, 32'h00);
      rd(IS, 32'h0);
      rd(IM, 32'h0);
      check(irq, 1'b0);
      $display("test reset done");
      // guard bits, bit by bit within one write
      wr(CS, 32'hC0);
      rd(CS, 32'h00);
      wr(CS, 32'h40);
      rd(CS, 32'h40);
      wr(CN, 32'hA5);
      rd(CN, 32'hA5);
      wr(CS, 32'h00);
      wr(CN, 32'h3C);
      rd(CN, 32'hA5);
      rd(IS, 32'h2);
      wr(IS, 32'h2);
      rd(IS, 32'h0);
      wr(CS, 32'h30);
      rd(CS, 32'h00);
      wr(CS, 32'h05);
      rd(CS, 32'h00);
      wr(CS, 32'h10);
      rd(CS, 32'h10);
      wr(CS, 32'h9D);
      rd(CS, 32'h11);
      wr(CS, 32'h92);
      rd(CS, 32'h11);
      wr(CS, 32'h90);
      rd(CS, 32'h10);
      $display("test guards done");
      // watchdog off holds count, then subclock source overflows
      wr(PM, 32'h04);
      rd(PM, 32'h04);
      wr(CS, 32'h50);
      wr(CN, 32'hFF);
      tick_on <= 1'b1;
      repeat (200) @(posedge pclk);
      rd(CN, 32'hFF);
      check(rst_cnt, 0);
      wr(CS, 32'h94);
      rd(CS, 32'h54);
      wait_rst(140);
      check(wdt_reset, 1'b1);
      tick_on = 1'b0;
      rd(CS, 32'h55);
      rd(CN, 32'h00);
      wr(IS, 32'h3);
      $display("test subclock done");
      // system clock source: FE needs two prescaler periods
      wr(PM, 32'h00);
      wr(CS, 32'h94);
      rd(CS, 32'h54);
      wr(CN, 32'hFE);
      wait_rst(17000);
      check(wdt_reset, 1'b1);
      check(cyc > 8192 && cyc <= 16400, 1'b1);
      rd(CS, 32'h55);
      rd(IS, 32'h1);
      check(irq, 1'b0);
      wr(IM, 32'h1);
      @(negedge pclk);
      check(irq, 1'b1);
      wr(IS, 32'h1);
      @(negedge pclk);
      check(irq, 1'b0);
      $display("test system clock done");
      // unmapped address
      rd(32'h00000200, 32'h0);
      check(last_err, 1'b1);
      $display("test unmapped done");
      report_and_stop();
   end
endmodule
